// *** rtl/ris_pkg.sv ***
// shared constants, register map and carrier types of the remote i/o slave link control
package ris_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TIMEOUT = 8'h04;
    localparam logic [7:0] OFS_PORT = 8'h08;
    localparam logic [7:0] OFS_IP = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_GW = 8'h14;
    localparam logic [7:0] OFS_MASTER_IP = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_CYC_CUR = 8'h20;
    localparam logic [7:0] OFS_CYC_MAX = 8'h24;
    localparam logic [7:0] OFS_CYC_MIN = 8'h28;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h2c;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h30;
    localparam logic [7:0] OFS_IRQ_EN = 8'h34;
    // field positions
    localparam int CTRL_SLAVE_BIT = 0;
    localparam int CTRL_FIXED_BIT = 1;
    localparam int IRQ_CONN_BIT = 0;
    localparam int IRQ_DISC_BIT = 1;
    localparam int IRQ_REJ_BIT = 2;
    localparam int IRQ_MAINT_BIT = 3;
    localparam int IRQ_W = 4;
    // reset values
    localparam logic [15:0] PORT_RST = 16'h083e; // 2110
    localparam logic [7:0] TIMEOUT_RST = 8'h0a; // 10 steps, 1000 ms
    localparam logic [7:0] TIMEOUT_MIN = 8'h01;
    // timeout step size and range in ms
    localparam int TIMEOUT_STEP_MS = 100;
    localparam int TIMEOUT_MAX_MS = 25500;
    // timing
    localparam int CLK_HZ = 20000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int FILT_MS = 3;
    localparam int BLINK_MS = 500;
    // fixed serial maintenance settings
    localparam int SER_BAUD = 115200;
    localparam logic [3:0] SER_DATA_BITS = 4'h7;
    localparam logic SER_PARITY_EVEN = 1'b1;
    localparam logic [1:0] SER_STOP_BITS = 2'h1;
    // i/o widths
    localparam int DIN_W = 16;
    localparam int DOUT_W = 16;
    localparam int AIN_N = 8;
    localparam int AIN_W = 16;

    typedef struct packed {
        logic fixed_addr;
        logic [31:0] ip;
        logic [31:0] mask;
        logic [31:0] gw;
        logic [15:0] port;
    } ris_netcfg_s;

    typedef struct packed {
        logic [DIN_W-1:0] din;
        logic [AIN_N*AIN_W-1:0] ain;
    } ris_resp_s;

    typedef struct packed {
        logic rio;
        logic [31:0] src_ip;
        logic [15:0] dst_port;
        logic [DOUT_W-1:0] outputs;
    } ris_req_s;
endpackage : ris_pkg

// *** rtl/ris_link_ctrl.sv ***
// remote i/o slave link control: connection state, timeout, cycle stats, led, restrictions
`timescale 1ns/100ps
module ris_link_ctrl #(
    parameter int TICK_CYC = ris_pkg::TICK_CYC,
    parameter int FILT_MS = ris_pkg::FILT_MS,
    parameter int BLINK_MS = ris_pkg::BLINK_MS
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // request from packet engine, answer back
    input wire logic req_valid_in,
    input wire ris_pkg::ris_req_s req_in,
    output logic resp_valid_out,
    output ris_pkg::ris_resp_s resp_out,
    // i/o
    input wire logic [ris_pkg::DIN_W-1:0] din_pin_in,
    input wire logic [ris_pkg::AIN_N*ris_pkg::AIN_W-1:0] ain_in,
    output logic [ris_pkg::DOUT_W-1:0] dout_out,
    // special relays and run/stop request, no effect in slave mode
    input wire logic force_outputs_off_relay_in,
    input wire logic hold_outputs_when_stopped_relay_in,
    input wire logic run_stop_req_in,
    // maintenance and monitor write attempts
    input wire logic maint_wr_in,
    input wire logic maint_wr_is_output_in,
    output logic maint_wr_ok_out,
    input wire logic monitor_wr_in,
    output logic monitor_wr_ok_out,
    // configuration and status outputs
    output ris_pkg::ris_netcfg_s netcfg_out,
    output logic [31:0] serial_baud_out,
    output logic [3:0] serial_data_bits_out,
    output logic serial_parity_even_out,
    output logic [1:0] serial_stop_bits_out,
    output logic serial_maint_mode_out,
    output logic [7:0] filter_ms_out,
    output logic running_out,
    output logic program_erase_out,
    output logic other_funcs_en_out,
    output logic led_out,
    output logic irq_out
);
    typedef enum logic [0:0] {
        RIS_DISC = 1'b0,
        RIS_CONN = 1'b1
    } ris_state_e;

    localparam int BLINK_W = $clog2(BLINK_MS + 1);
    localparam int TICK_W = $clog2(TICK_CYC + 1);
    localparam logic [15:0] MS_SAT = 16'hffff;
    localparam int IRQ_W_L = ris_pkg::IRQ_W;

    ris_state_e state_reg;
    logic slave_en_reg;
    logic fixed_addr_reg;
    logic [7:0] timeout_reg;
    logic [15:0] port_reg;
    logic [31:0] ip_reg;
    logic [31:0] mask_reg;
    logic [31:0] gw_reg;
    logic [31:0] master_ip_reg;
    logic [15:0] cyc_cur_reg;
    logic [15:0] cyc_max_reg;
    logic [15:0] cyc_min_reg;
    logic [IRQ_W_L-1:0] irq_stat_reg;
    logic [IRQ_W_L-1:0] irq_en_reg;
    logic [15:0] silent_ms_reg;
    logic [TICK_W-1:0] tick_cnt_reg;
    logic tick_ms;
    logic [BLINK_W-1:0] blink_cnt_reg;
    logic blink_reg;
    logic [ris_pkg::DIN_W-1:0] din_meta_reg;
    logic [ris_pkg::DIN_W-1:0] din_sync_reg;
    logic [ris_pkg::DIN_W-1:0] din_filt_reg;
    logic [ris_pkg::DIN_W-1:0] samp_reg [FILT_MS];
    logic [ris_pkg::DIN_W-1:0] all_hi;
    logic [ris_pkg::DIN_W-1:0] all_lo;
    logic req_ok;
    logic req_rej;
    logic timeout_hit;
    logic [15:0] timeout_ms;
    logic [IRQ_W_L-1:0] irq_ev;
    logic [IRQ_W_L-1:0] irq_clr;

    // write decode shared by every register
    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = reg_wr_in && (reg_addr_in == ofs);
    endfunction : wr_hit

    // clamp a timeout step count into 1..255
    function automatic logic [7:0] clamp_steps(input logic [7:0] v);
        clamp_steps = (v < ris_pkg::TIMEOUT_MIN) ? ris_pkg::TIMEOUT_MIN : v;
    endfunction : clamp_steps

    // 1 ms enable from the system clock divider
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tick_cnt_reg <= '0;
        end else if (tick_cnt_reg == TICK_W'(TICK_CYC - 1)) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end
    assign tick_ms = (tick_cnt_reg == TICK_W'(TICK_CYC - 1));

    // configuration registers
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            slave_en_reg <= 1'b0;
            fixed_addr_reg <= 1'b0;
            timeout_reg <= ris_pkg::TIMEOUT_RST;
            port_reg <= ris_pkg::PORT_RST;
            ip_reg <= '0;
            mask_reg <= '0;
            gw_reg <= '0;
            master_ip_reg <= '0;
            irq_en_reg <= '0;
        end else begin
            if (wr_hit(ris_pkg::OFS_CTRL)) begin
                slave_en_reg <= reg_wdata_in[ris_pkg::CTRL_SLAVE_BIT];
                fixed_addr_reg <= reg_wdata_in[ris_pkg::CTRL_FIXED_BIT];
            end
            if (wr_hit(ris_pkg::OFS_TIMEOUT)) begin
                timeout_reg <= clamp_steps(reg_wdata_in[7:0]);
            end
            if (wr_hit(ris_pkg::OFS_PORT)) begin
                port_reg <= reg_wdata_in[15:0];
            end
            if (wr_hit(ris_pkg::OFS_IP)) begin
                ip_reg <= reg_wdata_in;
            end
            if (wr_hit(ris_pkg::OFS_MASK)) begin
                mask_reg <= reg_wdata_in;
            end
            if (wr_hit(ris_pkg::OFS_GW)) begin
                gw_reg <= reg_wdata_in;
            end
            if (wr_hit(ris_pkg::OFS_MASTER_IP)) begin
                master_ip_reg <= reg_wdata_in;
            end
            if (wr_hit(ris_pkg::OFS_IRQ_EN)) begin
                irq_en_reg <= reg_wdata_in[IRQ_W_L-1:0];
            end
        end
    end

    // fixed settings matter only in fixed mode; the stack handles automatic
    assign netcfg_out = '{fixed_addr: fixed_addr_reg, ip: ip_reg, mask: mask_reg, gw: gw_reg, port: port_reg};

    // request qualification: right master, right port, remote i/o traffic only
    assign req_ok = req_valid_in && slave_en_reg && req_in.rio && (req_in.src_ip == master_ip_reg)
                    && (req_in.dst_port == port_reg);
    assign req_rej = req_valid_in && !req_ok;

    // timeout in ms: steps times step size
    assign timeout_ms = 16'(timeout_reg) * 16'(ris_pkg::TIMEOUT_STEP_MS);
    assign timeout_hit = (state_reg == RIS_CONN) && (silent_ms_reg >= timeout_ms);

    // silence in ms; an accepted request restarts it; saturates, never wraps
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            silent_ms_reg <= '0;
        end else if (req_ok) begin
            silent_ms_reg <= '0;
        end else if (tick_ms && silent_ms_reg != MS_SAT) begin
            silent_ms_reg <= silent_ms_reg + 16'h0001;
        end
    end

    // connection state
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= RIS_DISC;
        end else begin
            unique case (state_reg)
                RIS_DISC: begin
                    if (req_ok) begin
                        state_reg <= RIS_CONN;
                    end
                end
                RIS_CONN: begin
                    if (!slave_en_reg || (timeout_hit && !req_ok)) begin
                        state_reg <= RIS_DISC;
                    end
                end
            endcase
        end
    end

    // outputs follow accepted requests, hold while connected, off when disconnected, timed out or slave off; the force-off and hold relays never reach here
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dout_out <= '0;
        end else if (req_ok) begin
            dout_out <= req_in.outputs;
        end else if (state_reg == RIS_DISC || timeout_hit || !slave_en_reg) begin
            dout_out <= '0;
        end
    end

    // answer each accepted request in the next cycle; rejected ones get none
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            resp_valid_out <= 1'b0;
            resp_out <= '0;
        end else begin
            resp_valid_out <= req_ok;
            if (req_ok) begin
                resp_out <= '{din: din_filt_reg, ain: ain_in};
            end
        end
    end

    // pin synchroniser for digital inputs
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            din_meta_reg <= '0;
            din_sync_reg <= '0;
        end else begin
            din_meta_reg <= din_pin_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    // input filter: a bit moves only once every 1 ms sample agrees
    always_comb begin
        all_hi = '1;
        all_lo = '1;
        for (int i = 0; i < FILT_MS; i++) begin
            all_hi = all_hi & samp_reg[i];
            all_lo = all_lo & ~samp_reg[i];
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < FILT_MS; i++) begin
                samp_reg[i] <= '0;
            end
            din_filt_reg <= '0;
        end else if (tick_ms) begin
            samp_reg[0] <= din_sync_reg;
            for (int i = 1; i < FILT_MS; i++) begin
                samp_reg[i] <= samp_reg[i-1];
            end
            din_filt_reg <= all_hi | (din_filt_reg & ~all_lo);
        end
    end

    // cycle stats in ms between accepts, restarted at each connect
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cyc_cur_reg <= '0;
            cyc_max_reg <= '0;
            cyc_min_reg <= MS_SAT;
        end else if (req_ok && state_reg == RIS_DISC) begin
            cyc_cur_reg <= '0;
            cyc_max_reg <= '0;
            cyc_min_reg <= MS_SAT;
        end else if (req_ok) begin
            cyc_cur_reg <= silent_ms_reg;
            if (silent_ms_reg > cyc_max_reg) begin
                cyc_max_reg <= silent_ms_reg;
            end
            if (silent_ms_reg < cyc_min_reg) begin
                cyc_min_reg <= silent_ms_reg;
            end
        end
    end

    // status led: steady when connected, blinking when not
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            blink_cnt_reg <= '0;
            blink_reg <= 1'b0;
        end else if (tick_ms) begin
            if (blink_cnt_reg == BLINK_W'(BLINK_MS - 1)) begin
                blink_cnt_reg <= '0;
                blink_reg <= ~blink_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 1'b1;
            end
        end
    end
    assign led_out = (state_reg == RIS_CONN) ? 1'b1 : blink_reg;

    // slave mode: program erased on entry, other functions off
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            program_erase_out <= 1'b0;
        end else begin
            program_erase_out <= wr_hit(ris_pkg::OFS_CTRL) && reg_wdata_in[ris_pkg::CTRL_SLAVE_BIT]
                                 && !slave_en_reg;
        end
    end
    assign other_funcs_en_out = ~slave_en_reg;

    // run/stop request ignored: a slave always runs and refreshes
    assign running_out = 1'b1;

    // maintenance writes all but output relays; monitor never writes
    assign maint_wr_ok_out = maint_wr_in && !maint_wr_is_output_in;
    assign monitor_wr_ok_out = 1'b0;

    // fixed serial maintenance settings
    assign serial_maint_mode_out = 1'b1;
    assign serial_baud_out = 32'(ris_pkg::SER_BAUD);
    assign serial_data_bits_out = ris_pkg::SER_DATA_BITS;
    assign serial_parity_even_out = ris_pkg::SER_PARITY_EVEN;
    assign serial_stop_bits_out = ris_pkg::SER_STOP_BITS;
    assign filter_ms_out = 8'(FILT_MS);

    // interrupt events; a new event beats a clear in the same cycle
    assign irq_ev[ris_pkg::IRQ_CONN_BIT] = req_ok && state_reg == RIS_DISC;
    assign irq_ev[ris_pkg::IRQ_DISC_BIT] = state_reg == RIS_CONN && (!slave_en_reg || (timeout_hit && !req_ok));
    assign irq_ev[ris_pkg::IRQ_REJ_BIT] = req_rej;
    assign irq_ev[ris_pkg::IRQ_MAINT_BIT] = (maint_wr_in && maint_wr_is_output_in) || monitor_wr_in;
    assign irq_clr = wr_hit(ris_pkg::OFS_IRQ_CLR) ? reg_wdata_in[IRQ_W_L-1:0] : '0;

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
        end
    end
    assign irq_out = |(irq_stat_reg & irq_en_reg);

    // read data in the cycle after the strobe; unmapped and write-only read zero
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                ris_pkg::OFS_CTRL: reg_rdata_out <= {30'h0, fixed_addr_reg, slave_en_reg};
                ris_pkg::OFS_TIMEOUT: reg_rdata_out <= {24'h0, timeout_reg};
                ris_pkg::OFS_PORT: reg_rdata_out <= {16'h0, port_reg};
                ris_pkg::OFS_IP: reg_rdata_out <= ip_reg;
                ris_pkg::OFS_MASK: reg_rdata_out <= mask_reg;
                ris_pkg::OFS_GW: reg_rdata_out <= gw_reg;
                ris_pkg::OFS_MASTER_IP: reg_rdata_out <= master_ip_reg;
                ris_pkg::OFS_STATUS: reg_rdata_out <= {29'h0, force_outputs_off_relay_in
                                                       | hold_outputs_when_stopped_relay_in,
                                                       run_stop_req_in, state_reg == RIS_CONN};
                ris_pkg::OFS_CYC_CUR: reg_rdata_out <= {16'h0, cyc_cur_reg};
                ris_pkg::OFS_CYC_MAX: reg_rdata_out <= {16'h0, cyc_max_reg};
                ris_pkg::OFS_CYC_MIN: reg_rdata_out <= {16'h0, cyc_min_reg};
                ris_pkg::OFS_IRQ_STAT: reg_rdata_out <= {28'h0, irq_stat_reg};
                ris_pkg::OFS_IRQ_EN: reg_rdata_out <= {28'h0, irq_en_reg};
                default: reg_rdata_out <= '0;
            endcase
        end else begin
            reg_rdata_out <= '0;
        end
    end
endmodule : ris_link_ctrl

// *** verif/ris_link_ctrl_checker.sv ***
// assertion checker for the remote i/o slave link control
`timescale 1ns/100ps
module ris_link_ctrl_checker (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic req_valid_in,
    input wire ris_pkg::ris_req_s req_in,
    input wire logic resp_valid_out,
    input wire ris_pkg::ris_resp_s resp_out,
    input wire logic [ris_pkg::AIN_N*ris_pkg::AIN_W-1:0] ain_in,
    input wire logic [ris_pkg::DOUT_W-1:0] dout_out,
    input wire logic maint_wr_in,
    input wire logic maint_wr_is_output_in,
    input wire logic maint_wr_ok_out,
    input wire logic monitor_wr_ok_out,
    input wire logic [31:0] serial_baud_out,
    input wire logic [3:0] serial_data_bits_out,
    input wire logic serial_parity_even_out,
    input wire logic [1:0] serial_stop_bits_out,
    input wire logic [7:0] filter_ms_out,
    input wire logic running_out,
    input wire logic program_erase_out,
    input wire logic other_funcs_en_out,
    input wire logic led_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    // an answer only ever follows a remote i/o request
    property p_resp_cause; resp_valid_out |-> $past(req_valid_in) && $past(req_in.rio); endproperty
    a_resp_cause: assert property (p_resp_cause) else $error("answer without a remote request");
    property p_resp_outputs; resp_valid_out |-> dout_out == $past(req_in.outputs); endproperty
    a_resp_outputs: assert property (p_resp_outputs) else $error("outputs differ from request");
    property p_resp_ain; resp_valid_out |-> resp_out.ain == $past(ain_in); endproperty
    a_resp_ain: assert property (p_resp_ain) else $error("analog values not reported");
    property p_resp_led; resp_valid_out |-> led_out; endproperty
    a_resp_led: assert property (p_resp_led) else $error("led not steady when connected");
    // outputs rise only from a request, never from a relay
    property p_dout_cause; $changed(dout_out) && dout_out != '0 |-> $past(req_valid_in); endproperty
    a_dout_cause: assert property (p_dout_cause) else $error("outputs changed without request");
    property p_serial;
        serial_baud_out == 32'h0001c200 && serial_data_bits_out == 4'h7 && serial_parity_even_out
            && serial_stop_bits_out == 2'h1;
    endproperty
    a_serial: assert property (p_serial) else $error("serial settings not fixed");
    property p_fixed; filter_ms_out == 8'h03 && running_out; endproperty
    a_fixed: assert property (p_fixed) else $error("filter or run state not fixed");
    property p_maint;
        maint_wr_ok_out == (maint_wr_in && !maint_wr_is_output_in) && !monitor_wr_ok_out;
    endproperty
    a_maint: assert property (p_maint) else $error("write permission wrong");
    property p_erase; program_erase_out |-> !other_funcs_en_out ##1 !program_erase_out; endproperty
    a_erase: assert property (p_erase) else $error("erase pulse wrong");

    c_resp: cover property (resp_valid_out);
    c_drop: cover property ($changed(dout_out) && dout_out == '0);
    c_erase: cover property (program_erase_out);
    c_irq: cover property (irq_out);
endmodule : ris_link_ctrl_checker

bind ris_link_ctrl ris_link_ctrl_checker chk_u (.clk_sys_in, .resetn_in, .req_valid_in, .req_in,
    .resp_valid_out, .resp_out, .ain_in, .dout_out, .maint_wr_in, .maint_wr_is_output_in, .maint_wr_ok_out,
    .monitor_wr_ok_out, .serial_baud_out, .serial_data_bits_out, .serial_parity_even_out,
    .serial_stop_bits_out, .filter_ms_out, .running_out, .program_erase_out, .other_funcs_en_out,
    .led_out, .irq_out);

// *** verif/ris_master_model.sv ***
// remote i/o master model: one request at a time
`timescale 1ns/100ps
module ris_master_model (
    input wire logic clk_sys_in,
    input wire logic resp_valid_in,
    output logic req_valid_out,
    output ris_pkg::ris_req_s req_out
);
    initial {req_valid_out, req_out} = '0;

    // released fields show the inverse, so stale data never looks live
    task automatic send(input logic rio, input logic [31:0] ip, input logic [15:0] port,
                        input logic [15:0] outs, output logic answered);
        @(posedge clk_sys_in);
        req_valid_out <= 1'b1;
        req_out <= ris_pkg::ris_req_s'({rio, ip, port, outs});
        @(posedge clk_sys_in);
        req_valid_out <= 1'b0;
        req_out <= ris_pkg::ris_req_s'(~{rio, ip, port, outs});
        // the answer comes one cycle later or never; no new request before it
        #1 answered = (resp_valid_in === 1'b1);
    endtask : send
endmodule : ris_master_model

// *** verif/ris_link_ctrl_test.sv ***
// self-checking bench for the remote i/o slave link control
`timescale 1ns/100ps
module ris_link_ctrl_test;
    localparam int TICK = 20;
    localparam logic [31:0] MIP = 32'h0a000001;
    logic clk_sys_in, resetn_in, reg_wr_in, reg_rd_in, req_valid_in, resp_valid_out, led_out, irq_out, got;
    logic force_outputs_off_relay_in, hold_outputs_when_stopped_relay_in, run_stop_req_in;
    logic maint_wr_in, maint_wr_is_output_in, maint_wr_ok_out, monitor_wr_in, other_funcs_en_out, led_a;
    logic [7:0] reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out;
    logic [15:0] din_pin_in, dout_out;
    logic [ris_pkg::AIN_N*ris_pkg::AIN_W-1:0] ain_in;
    ris_pkg::ris_req_s req_in;
    ris_pkg::ris_resp_s resp_out;
    ris_pkg::ris_netcfg_s netcfg_out;
    int errors, num_checks;

    // short tick and blink keep the run short
    ris_link_ctrl #(.TICK_CYC(TICK), .FILT_MS(3), .BLINK_MS(4)) dut_u (.clk_sys_in, .resetn_in,
        .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .req_valid_in, .req_in,
        .resp_valid_out, .resp_out, .din_pin_in, .ain_in, .dout_out, .force_outputs_off_relay_in,
        .hold_outputs_when_stopped_relay_in, .run_stop_req_in, .maint_wr_in, .maint_wr_is_output_in,
        .maint_wr_ok_out, .monitor_wr_in, .monitor_wr_ok_out(), .netcfg_out, .serial_baud_out(),
        .serial_data_bits_out(), .serial_parity_even_out(), .serial_stop_bits_out(), .serial_maint_mode_out(),
        .filter_ms_out(), .running_out(), .program_erase_out(), .other_funcs_en_out, .led_out, .irq_out);

    ris_master_model mst_u (.clk_sys_in, .resp_valid_in(resp_valid_out), .req_valid_out(req_valid_in),
        .req_out(req_in));

    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    task automatic summarize;
        if (errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 check(reg_rdata_out, exp);
    endtask : rd

    task automatic xfer(input logic rio, input logic [31:0] ip, input logic [15:0] port,
                        input logic [15:0] outs, input logic exp);
        mst_u.send(rio, ip, port, outs, got);
        check({31'h0, got}, {31'h0, exp});
    endtask : xfer

    // request cycles taken off so accepts lie whole ms apart
    task automatic gap(input int ms);
        repeat (ms * TICK - 2) @(posedge clk_sys_in);
    endtask : gap

    task automatic t_reset;
        rd(ris_pkg::OFS_TIMEOUT, 32'h0000000a);
        rd(ris_pkg::OFS_PORT, 32'h0000083e);
        rd(ris_pkg::OFS_CYC_MIN, 32'h0000ffff);
        rd(8'hfc, 32'h00000000);
        check({16'h0, dout_out}, 32'h0);
    endtask : t_reset

    task automatic t_config;
        wr(ris_pkg::OFS_TIMEOUT, 32'h0);
        rd(ris_pkg::OFS_TIMEOUT, 32'h00000001);
        wr(ris_pkg::OFS_TIMEOUT, 32'h000000ff);
        rd(ris_pkg::OFS_TIMEOUT, 32'h000000ff);
        wr(ris_pkg::OFS_TIMEOUT, 32'h00000001);
        wr(ris_pkg::OFS_PORT, 32'h0000ffff);
        wr(ris_pkg::OFS_IP, 32'hc0a80002);
        wr(ris_pkg::OFS_MASK, 32'hffffff00);
        wr(ris_pkg::OFS_GW, 32'hc0a80001);
        wr(ris_pkg::OFS_CTRL, 32'h00000003);
        #1 check({31'h0, netcfg_out === {1'b1, 64'hc0a80002ffffff00, 32'hc0a80001, 16'hffff}}, 32'h1);
        check({31'h0, other_funcs_en_out}, 32'h0);
        wr(ris_pkg::OFS_PORT, 32'h0000083e);
        wr(ris_pkg::OFS_MASTER_IP, MIP);
        wr(ris_pkg::OFS_IRQ_EN, 32'h00000005);
    endtask : t_config

    task automatic t_reject;
        xfer(1'b1, MIP + 32'h1, 16'h083e, 16'h00ff, 1'b0);
        xfer(1'b1, MIP, 16'h083f, 16'h00ff, 1'b0);
        xfer(1'b0, MIP, 16'h083e, 16'h00ff, 1'b0);
        check({16'h0, dout_out}, 32'h0);
        rd(ris_pkg::OFS_IRQ_STAT, 32'h00000004);
        check({31'h0, irq_out}, 32'h1);
        wr(ris_pkg::OFS_IRQ_CLR, 32'h00000004);
        rd(ris_pkg::OFS_IRQ_STAT, 32'h0);
        check({31'h0, irq_out}, 32'h0);
    endtask : t_reject

    // relays and run/stop stay high from here on
    task automatic t_connect;
        force_outputs_off_relay_in <= 1'b1;
        hold_outputs_when_stopped_relay_in <= 1'b1;
        run_stop_req_in <= 1'b1;
        repeat (5 * TICK) @(posedge clk_sys_in);
        xfer(1'b1, MIP, 16'h083e, 16'ha5c3, 1'b1);
        check({16'h0, dout_out}, 32'h0000a5c3);
        check({31'h0, led_out}, 32'h1);
        check({16'h0, resp_out.din}, {16'h0, din_pin_in});
        check({31'h0, resp_out.ain === ain_in}, 32'h1);
        check({31'h0, irq_out}, 32'h1);
        rd(ris_pkg::OFS_STATUS, 32'h00000007);
        wr(ris_pkg::OFS_IRQ_CLR, 32'h00000001);
        maint_wr_in <= 1'b1;
        maint_wr_is_output_in <= 1'b1;
        #1 check({31'h0, maint_wr_ok_out}, 32'h0);
        maint_wr_is_output_in <= 1'b0;
        #1 check({31'h0, maint_wr_ok_out}, 32'h1);
    endtask : t_connect

    task automatic t_cycles;
        gap(6);
        xfer(1'b1, MIP, 16'h083e, 16'h0001, 1'b1);
        gap(5);
        xfer(1'b1, MIP, 16'h083e, 16'h0002, 1'b1);
        gap(8);
        xfer(1'b1, MIP, 16'h083e, 16'h0003, 1'b1);
        rd(ris_pkg::OFS_CYC_CUR, 32'h00000008);
        rd(ris_pkg::OFS_CYC_MAX, 32'h00000008);
        rd(ris_pkg::OFS_CYC_MIN, 32'h00000005);
    endtask : t_cycles

    task automatic t_timeout;
        gap(90);
        xfer(1'b1, MIP, 16'h083e, 16'h0f0f, 1'b1);
        gap(99);
        #1 check({16'h0, dout_out}, 32'h00000f0f);
        repeat (2 * TICK) @(posedge clk_sys_in);
        #1 check({16'h0, dout_out}, 32'h0);
        led_a = led_out;
        repeat (4 * TICK) @(posedge clk_sys_in);
        #1 check({31'h0, led_a ^ led_out}, 32'h1);
        rd(ris_pkg::OFS_STATUS, 32'h00000006);
        xfer(1'b1, MIP, 16'h083e, 16'h0033, 1'b1);
        rd(ris_pkg::OFS_CYC_MAX, 32'h0);
        rd(ris_pkg::OFS_CYC_MIN, 32'h0000ffff);
        wr(ris_pkg::OFS_CTRL, 32'h0);
        @(posedge clk_sys_in);
        #1 check({16'h0, dout_out}, 32'h0);
        check({31'h0, other_funcs_en_out}, 32'h1);
        xfer(1'b1, MIP, 16'h083e, 16'h0033, 1'b0);
    endtask : t_timeout

    initial begin
        {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        {force_outputs_off_relay_in, hold_outputs_when_stopped_relay_in, run_stop_req_in} = '0;
        {maint_wr_in, maint_wr_is_output_in, monitor_wr_in} = '0;
        din_pin_in = 16'h1234;
        ain_in = {8{16'h5a0f}};
        errors = 0;
        num_checks = 0;
        resetn_in = 1'b0;
        repeat (10) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        t_reset;
        t_config;
        t_reject;
        t_connect;
        t_cycles;
        t_timeout;
        summarize;
    end

    // watchdog, ten times the expected run
    initial begin
        repeat (50000) @(posedge clk_sys_in);
        errors++;
        summarize;
    end
endmodule : ris_link_ctrl_test
